/* File: rtl/barsc_pkg.sv */
package barsc_pkg;

    // time base
    localparam int CLK_HZ           = 10_000_000;
    localparam int US_PER_S         = 1_000_000;
    localparam int TICK_CYCLES      = CLK_HZ / US_PER_S;
    localparam int DHZ_PER_HZ       = 10;

    // register addresses on the link
    localparam logic [1:0] ADDR_SETUP  = 2'h0;
    localparam logic [1:0] ADDR_PERIOD = 2'h1;
    localparam logic [1:0] ADDR_TRIM   = 2'h2;

    // setup byte layout
    localparam int RATE_LSB         = 0;
    localparam int RATE_W           = 4;
    localparam int RANGE_LSB        = 4;
    localparam int RANGE_W          = 3;
    localparam int EXT_BIT          = 6;
    localparam int RSVD_BIT         = 7;
    localparam logic [3:0] RATE_MAX  = 4'hD;
    localparam logic [3:0] RATE_SYNC = 4'hE;
    localparam logic [3:0] RATE_RSVD = 4'hF;

    // period limits in microseconds, quarter-cycle divisor and settle length in bus cycles
    localparam int PERIOD_MIN_US    = 50;
    localparam int SYNC_MIN_US      = 200;
    localparam int PERIOD_MAX_US    = 2000;
    localparam int QUARTER_DIV      = 4;
    localparam int JITTER_SPLIT_US  = 1500;
    localparam int SETTLE_BUS_CYC   = 150;

    // clock trim
    localparam int TRIM_LIMIT       = 50;
    localparam int TRIM_PPM_STEP    = 200;
    localparam int PPM_FULL         = 1_000_000;
    localparam int SERIAL_MOD       = 100;
    localparam int SERIAL_MID       = 50;

    // status byte
    localparam int STAT_NOSYNC_BIT  = 2;

    // reset values
    localparam logic [7:0]  SETUP_RST  = 8'h00;
    localparam logic [15:0] PERIOD_RST = 16'h03E8;
    localparam logic [7:0]  TRIM_RST   = 8'h00;

    typedef enum logic [3:0] {
        DS_FREE   = 4'h1,
        DS_SETTLE = 4'h2,
        DS_LOCK   = 4'h4,
        DS_NOLOCK = 4'h8
    } barsc_dev_fsm_t;

    typedef enum logic [1:0] {
        HS_IDLE  = 2'h1,
        HS_WRITE = 2'h2
    } barsc_host_fsm_t;

    // output data rate in tenths of a sample per second, zero for no rate
    function automatic int rate_dhz(input logic [3:0] code);
        case (code)
            4'h0: rate_dhz = 25;
            4'h1: rate_dhz = 50;
            4'h2: rate_dhz = 100;
            4'h3: rate_dhz = 150;
            4'h4: rate_dhz = 250;
            4'h5: rate_dhz = 300;
            4'h6: rate_dhz = 500;
            4'h7: rate_dhz = 600;
            4'h8: rate_dhz = 1000;
            4'h9: rate_dhz = 5000;
            4'hA: rate_dhz = 10000;
            4'hB: rate_dhz = 20000;
            4'hC: rate_dhz = 37500;
            4'hD: rate_dhz = 75000;
            default: rate_dhz = 0;
        endcase
    endfunction

    // full scale in mV/V for the three range bits
    function automatic logic [8:0] range_mvv(input logic [2:0] code);
        case (code)
            3'h0: range_mvv = 9'h010;
            3'h1: range_mvv = 9'h008;
            3'h2: range_mvv = 9'h004;
            3'h3: range_mvv = 9'h002;
            3'h4: range_mvv = 9'h100;
            3'h5: range_mvv = 9'h080;
            3'h6: range_mvv = 9'h040;
            default: range_mvv = 9'h020;
        endcase
    endfunction

endpackage

/* File: rtl/barsc_link_if.sv */
`timescale 1ns/1ns
interface barsc_link_if;
    logic        cyc_pulse;
    logic        wr_en;
    logic [1:0]  wr_addr;
    logic [15:0] wr_data;
    logic [7:0]  state_byte;

    modport dev  (input cyc_pulse, input wr_en, input wr_addr, input wr_data, output state_byte);
    modport host (output cyc_pulse, output wr_en, output wr_addr, output wr_data, input state_byte);
endinterface

/* File: rtl/barsc_device.sv */
`timescale 1ns/1ns
module barsc_device
    import barsc_pkg::*;
#(
    parameter int SAMPLE_CLK_HZ = 10_000_000,
    parameter int SERIAL_NO     = 1234
)
(
    input  wire logic   sys_clk,
    input  wire logic   rst,
    barsc_link_if.dev   link,
    output logic        conv_strobe,
    output logic        conv_valid,
    output logic        sync_mode,
    output logic [3:0]  rate_code,
    output logic [8:0]  range_full_scale,
    output logic        range_extended
);

    typedef struct packed {
        barsc_dev_fsm_t fsm;
        logic [7:0]     setup;
        logic [15:0]    period;
        logic [7:0]     trim;
        logic [7:0]     tick_cnt;
        logic [15:0]    us_cnt;
        logic [15:0]    bus_us;
        logic           seen_pulse;
        logic           have_cycle;
        logic [7:0]     settle_cnt;
        logic [31:0]    conv_cnt;
        logic           strobe;
        logic           valid;
        logic           sync;
        logic [8:0]     fs;
        logic [7:0]     state_byte;
    } barsc_dev_st_t;

    barsc_dev_st_t st_r;
    barsc_dev_st_t st_nxt;

    // effective trim steps; a bad setting falls back to SERIAL_MID minus the serial number modulo SERIAL_MOD
    function automatic int trim_steps(input logic [7:0] t);
        int s;
        s = int'($signed(t));
        if (s > TRIM_LIMIT || s < -TRIM_LIMIT)
            trim_steps = SERIAL_MID - (SERIAL_NO % SERIAL_MOD);
        else
            trim_steps = s;
    endfunction

    // free-running period in clocks, shortened as the converter clock speeds up
    function automatic logic [31:0] free_cycles(input logic [3:0] code, input logic [7:0] t);
        longint nom;
        longint adj;
        nom = 0;
        adj = 0;
        if (rate_dhz(code) != 0)
        begin
            nom = longint'(SAMPLE_CLK_HZ) * DHZ_PER_HZ / rate_dhz(code);
            adj = nom - (nom * trim_steps(t) * TRIM_PPM_STEP) / PPM_FULL;
        end
        free_cycles = 32'(adj);
    endfunction

    // true when b is a whole divisor of a
    function automatic logic divides(input logic [15:0] a, input logic [15:0] b);
        divides = (b != 16'h0000) && ((a % b) == 16'h0000);
    endfunction

    always_comb
    begin
        logic        us_tick;
        logic        sync_sel;
        logic        lock_ok;
        logic        period_chg;
        logic        realign;
        logic [31:0] target;
        us_tick    = 1'b0;
        sync_sel   = 1'b0;
        lock_ok    = 1'b0;
        period_chg = 1'b0;
        realign    = 1'b0;
        target     = 32'h0000_0000;
        st_nxt     = st_r;
        st_nxt.strobe = 1'b0;

        // register writes from the master
        if (link.wr_en)
        begin
            case (link.wr_addr)
                ADDR_SETUP:  st_nxt.setup = link.wr_data[7:0];
                ADDR_PERIOD:
                begin
                    st_nxt.period = link.wr_data;
                    period_chg    = (link.wr_data != st_r.period);
                end
                ADDR_TRIM:   st_nxt.trim = link.wr_data[7:0];
                default:     st_nxt.trim = st_r.trim;
            endcase
        end
        sync_sel = (st_r.setup[RATE_LSB +: RATE_W] == RATE_SYNC);

        // microsecond grid restarted at each bus pulse, so cycle time is exact
        us_tick = (st_r.tick_cnt == 8'(TICK_CYCLES - 1));
        if (link.cyc_pulse)
        begin
            st_nxt.tick_cnt   = 8'h00;
            st_nxt.us_cnt     = 16'h0000;
            // the pulse edge closes the last microsecond, else the cycle reads one short
            st_nxt.bus_us     = st_r.us_cnt + {15'h0000, us_tick};
            st_nxt.seen_pulse = 1'b1;
            st_nxt.have_cycle = st_r.seen_pulse;
        end
        else
        begin
            st_nxt.tick_cnt = us_tick ? 8'h00 : st_r.tick_cnt + 8'h01;
            if (us_tick && st_r.us_cnt != 16'hFFFF)
                st_nxt.us_cnt = st_r.us_cnt + 16'h0001;
        end

        // lock needs range, quarter-cycle floor and whole ratio either way
        lock_ok = st_r.have_cycle
                  && st_r.period >= 16'(SYNC_MIN_US)
                  && st_r.period <= 16'(PERIOD_MAX_US)
                  && (18'(st_r.period) * 18'(QUARTER_DIV)) >= 18'(st_r.bus_us)
                  && (divides(st_r.bus_us, st_r.period) || divides(st_r.period, st_r.bus_us));

        // lock state machine
        case (st_r.fsm)
            DS_FREE:
            begin
                if (sync_sel)
                begin
                    st_nxt.fsm        = DS_SETTLE;
                    st_nxt.settle_cnt = 8'h00;
                end
            end
            DS_SETTLE:
            begin
                if (link.cyc_pulse)
                begin
                    st_nxt.settle_cnt = st_r.settle_cnt + 8'h01;
                    if (st_r.settle_cnt == 8'(SETTLE_BUS_CYC - 1))
                    begin
                        st_nxt.fsm = lock_ok ? DS_LOCK : DS_NOLOCK;
                        realign    = lock_ok;
                    end
                end
            end
            DS_LOCK:
            begin
                if (!lock_ok)
                    st_nxt.fsm = DS_NOLOCK;
            end
            DS_NOLOCK:
            begin
                // a ratio that becomes valid still has to settle first
                if (lock_ok)
                begin
                    st_nxt.fsm        = DS_SETTLE;
                    st_nxt.settle_cnt = 8'h00;
                end
            end
            default: st_nxt.fsm = DS_FREE;
        endcase

        // leaving sync returns to free run; changing the period restarts settling
        if (!sync_sel)
            st_nxt.fsm = DS_FREE;
        else if (period_chg && st_r.fsm != DS_FREE)
        begin
            st_nxt.fsm        = DS_SETTLE;
            st_nxt.settle_cnt = 8'h00;
            realign           = 1'b0;
        end

        // conversion timer; sync counts whole microseconds so there is no drift
        if (sync_sel)
            target = 32'(st_r.period) * 32'(TICK_CYCLES);
        else
            target = free_cycles(st_r.setup[RATE_LSB +: RATE_W], st_r.trim);
        if (st_r.fsm == DS_LOCK && link.cyc_pulse && st_r.period <= st_r.bus_us)
            realign = 1'b1;
        if (target == 32'h0000_0000)
            st_nxt.conv_cnt = 32'h0000_0000; // reserved code: converter idle
        else if (realign)
        begin
            st_nxt.conv_cnt = 32'h0000_0000; // same phase as a normal strobe, no short interval
            st_nxt.strobe   = 1'b1;
        end
        else if (st_r.conv_cnt >= target - 32'h0000_0001)
        begin
            st_nxt.conv_cnt = 32'h0000_0000;
            st_nxt.strobe   = 1'b1;
        end
        else
            st_nxt.conv_cnt = st_r.conv_cnt + 32'h0000_0001;

        // range decode and status
        st_nxt.fs = range_mvv(st_r.setup[RANGE_LSB +: RANGE_W]);
        st_nxt.state_byte = 8'h00;
        st_nxt.state_byte[STAT_NOSYNC_BIT] = (st_r.fsm == DS_SETTLE) || (st_r.fsm == DS_NOLOCK);
        st_nxt.valid = (st_r.fsm == DS_LOCK)
                       || (st_r.fsm == DS_FREE && st_r.setup[RATE_LSB +: RATE_W] <= RATE_MAX);
        st_nxt.sync  = (st_nxt.fsm != DS_FREE); // registered copy keeps the output glitch free
    end

    // single state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r            <= '0;
            st_r.fsm        <= DS_FREE;
            st_r.setup      <= SETUP_RST;
            st_r.period     <= PERIOD_RST;
            st_r.trim       <= TRIM_RST;
            st_r.fs         <= range_mvv(SETUP_RST[RANGE_LSB +: RANGE_W]);
            st_r.valid      <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign link.state_byte  = st_r.state_byte;
    assign conv_strobe      = st_r.strobe;
    assign conv_valid       = st_r.valid;
    assign sync_mode        = st_r.sync;
    assign rate_code        = st_r.setup[RATE_LSB +: RATE_W];
    assign range_full_scale = st_r.fs;
    assign range_extended   = st_r.setup[EXT_BIT];

endmodule // barsc_device

/* File: rtl/barsc_host.sv */
`timescale 1ns/1ns
module barsc_host
    import barsc_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   rst,
    barsc_link_if.host  link,
    input  wire logic [15:0] bus_cycle_us,
    input  wire logic   cfg_wr,
    input  wire logic [1:0]  cfg_addr,
    input  wire logic [15:0] cfg_data,
    output logic        cfg_ready,
    output logic        bus_tick,
    output logic [7:0]  state_byte
);

    typedef struct packed {
        barsc_host_fsm_t fsm;
        logic [7:0]      tick_cnt;
        logic [15:0]     us_cnt;
        logic            pulse;
        logic            wr_en;
        logic [1:0]      wr_addr;
        logic [15:0]     wr_data;
        logic            sync_sel;
        logic            ready;
        logic [7:0]      state_byte;
    } barsc_host_st_t;

    barsc_host_st_t st_r;
    barsc_host_st_t st_nxt;

    always_comb
    begin
        logic        us_tick;
        logic [15:0] lo;
        logic [15:0] quarter;
        logic [15:0] d;
        us_tick = (st_r.tick_cnt == 8'(TICK_CYCLES - 1));
        lo      = 16'(PERIOD_MIN_US);
        quarter = (bus_cycle_us + 16'(QUARTER_DIV - 1)) / 16'(QUARTER_DIV);
        d       = cfg_data;
        st_nxt  = st_r;
        st_nxt.pulse = 1'b0;
        st_nxt.wr_en = 1'b0;

        // bus cycle generator; a zero cycle time stops the bus
        st_nxt.tick_cnt = us_tick ? 8'h00 : st_r.tick_cnt + 8'h01;
        if (us_tick)
        begin
            if (bus_cycle_us != 16'h0000 && st_r.us_cnt >= bus_cycle_us - 16'h0001)
            begin
                st_nxt.us_cnt = 16'h0000;
                st_nxt.pulse  = 1'b1;
            end
            else
                st_nxt.us_cnt = st_r.us_cnt + 16'h0001;
        end
        if (st_r.pulse)
            st_nxt.state_byte = link.state_byte;

        // sanitise the written value before it goes out
        if (st_r.sync_sel)
        begin
            lo = 16'(SYNC_MIN_US);
            if (quarter > lo)
                lo = quarter;
        end
        if (cfg_addr == ADDR_PERIOD)
        begin
            if (d < lo)
                d = lo;
            else if (d > 16'(PERIOD_MAX_US))
                d = 16'(PERIOD_MAX_US);
        end
        else if (cfg_addr == ADDR_SETUP)
            d[15:RSVD_BIT] = '0;

        // one write in flight
        case (st_r.fsm)
            HS_IDLE:
            begin
                if (cfg_wr && st_r.ready)
                begin
                    st_nxt.fsm     = HS_WRITE;
                    st_nxt.wr_en   = 1'b1;
                    st_nxt.wr_addr = cfg_addr;
                    st_nxt.wr_data = d;
                    st_nxt.ready   = 1'b0;
                    if (cfg_addr == ADDR_SETUP)
                        st_nxt.sync_sel = (d[RATE_LSB +: RATE_W] == RATE_SYNC);
                end
            end
            HS_WRITE:
            begin
                st_nxt.fsm   = HS_IDLE;
                st_nxt.ready = 1'b1;
            end
            default:
            begin
                st_nxt.fsm   = HS_IDLE;
                st_nxt.ready = 1'b1;
            end
        endcase
    end

    // single state register
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            st_r       <= '0;
            st_r.fsm   <= HS_IDLE;
            st_r.ready <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    assign link.cyc_pulse = st_r.pulse;
    assign link.wr_en     = st_r.wr_en;
    assign link.wr_addr   = st_r.wr_addr;
    assign link.wr_data   = st_r.wr_data;
    assign cfg_ready      = st_r.ready;
    assign bus_tick       = st_r.pulse;
    assign state_byte     = st_r.state_byte;

endmodule // barsc_host

/* File: bench/barsc_props.sv */
`timescale 1ns/1ns
module barsc_props
    import barsc_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cyc_pulse,
    input wire logic        wr_en,
    input wire logic [1:0]  wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [7:0]  state_byte
);
    logic        sync_r;
    logic [7:0]  cnt_r;
    logic [15:0] per_r;
    logic [19:0] gcnt_r;
    logic [19:0] gap_r;
    wire         set_w = wr_en && wr_addr == ADDR_SETUP;
    wire         per_w = wr_en && wr_addr == ADDR_PERIOD;

    // mirror of sync entry; the count is never below the device's, so no false early alarm
    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            sync_r <= 1'b0;
            cnt_r  <= 8'h00;
            per_r  <= PERIOD_RST;
            gcnt_r <= 20'h00000;
            gap_r  <= 20'h00000;
        end
        else
        begin
            gcnt_r <= cyc_pulse ? 20'h00000 : gcnt_r + 20'h00001;
            if (cyc_pulse)
                gap_r <= gcnt_r + 20'h00001;
            if (set_w)
                sync_r <= wr_data[3:0] == RATE_SYNC;
            if (per_w)
                per_r <= wr_data;
            if ((set_w && !sync_r) || (per_w && wr_data != per_r))
                cnt_r <= 8'h00;
            else if (cyc_pulse && sync_r && cnt_r != 8'hFF)
                cnt_r <= cnt_r + 8'h01;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_sync_enter;
        set_w && wr_data[3:0] == RATE_SYNC && !sync_r;
    endsequence
    sequence s_settling;
        sync_r && cnt_r < 8'd148 && state_byte[STAT_NOSYNC_BIT];
    endsequence

    property p_settle_enter;
        s_sync_enter |-> ##[1:4] state_byte[STAT_NOSYNC_BIT];
    endproperty
    a_settle_enter: assert property (p_settle_enter) else $error("not-sync bit missing after sync entry");
    property p_settle_hold;
        s_settling |=> state_byte[STAT_NOSYNC_BIT];
    endproperty
    a_settle_hold: assert property (p_settle_hold) else $error("not-sync bit dropped while settling");
    property p_no_early_lock;
        $fell(state_byte[STAT_NOSYNC_BIT]) && sync_r |-> cnt_r >= 8'd150;
    endproperty
    a_no_early_lock: assert property (p_no_early_lock) else $error("lock reported before settling ended");
    property p_state_rsvd;
        (state_byte & 8'hFB) == 8'h00;
    endproperty
    a_state_rsvd: assert property (p_state_rsvd) else $error("status bits other than not-sync set");
    property p_setup_top;
        set_w |-> wr_data[15:7] == 9'h000;
    endproperty
    a_setup_top: assert property (p_setup_top) else $error("setup write with top bits set");
    property p_period_range;
        per_w |-> wr_data >= 16'd50 && wr_data <= 16'd2000;
    endproperty
    a_period_range: assert property (p_period_range) else $error("period write out of range");
    property p_sync_period;
        per_w && sync_r |-> wr_data >= 16'd200;
    endproperty
    a_sync_period: assert property (p_sync_period) else $error("sync period below minimum");
    property p_quarter;
        per_w && sync_r && gap_r != 20'h00000 |-> 32'(wr_data) * 40 >= 32'(gap_r);
    endproperty
    a_quarter: assert property (p_quarter) else $error("sync period below quarter bus cycle");
endmodule // barsc_props

/* File: bench/bridge_adc_rate_sync_control_test.sv */
`timescale 1ns/1ns
module bridge_adc_rate_sync_control_test
    import barsc_pkg::*;
;
    localparam int SERIAL = 1275; // arbitrary serial number
    logic        sys_clk, rst, cfg_wr, cfg_ready, bus_tick;
    logic        conv_strobe, conv_valid, sync_mode, range_extended;
    logic [15:0] bus_cycle_us, cfg_data;
    logic [1:0]  cfg_addr;
    logic [7:0]  state_byte;
    logic [3:0]  rate_code;
    logic [8:0]  range_full_scale;
    int          n_fail, checks_done, per;
    logic [31:0] lfsr_r;
    logic [15:0] trims[8] = '{16'h0000, 16'h0032, 16'hFFCE, 16'h0019, 16'h0100, 16'h0033, 16'h0080, 16'h1232};

    barsc_link_if barsc_link_if_i ();
    barsc_device #(.SAMPLE_CLK_HZ(10000), .SERIAL_NO(SERIAL)) barsc_device_i (.sys_clk(sys_clk), .rst(rst),
        .link(barsc_link_if_i.dev), .conv_strobe(conv_strobe), .conv_valid(conv_valid), .sync_mode(sync_mode),
        .rate_code(rate_code), .range_full_scale(range_full_scale), .range_extended(range_extended));
    barsc_host barsc_host_i (.sys_clk(sys_clk), .rst(rst), .link(barsc_link_if_i.host),
        .bus_cycle_us(bus_cycle_us), .cfg_wr(cfg_wr), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
        .cfg_ready(cfg_ready), .bus_tick(bus_tick), .state_byte(state_byte));
    barsc_props barsc_props_i (.sys_clk(sys_clk), .rst(rst), .cyc_pulse(barsc_link_if_i.cyc_pulse),
        .wr_en(barsc_link_if_i.wr_en), .wr_addr(barsc_link_if_i.wr_addr), .wr_data(barsc_link_if_i.wr_data),
        .state_byte(barsc_link_if_i.state_byte));

    // 10 MHz system clock
    always #50 sys_clk = ~sys_clk;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // shifts by halving, independent of the design's table
    function automatic logic [8:0] exp_range(input logic [2:0] c);
        return c[2] ? (9'h100 >> c[1:0]) : (9'h010 >> c[1:0]);
    endfunction
    function automatic int exp_dhz(input int c);
        int t[14] = '{25, 50, 100, 150, 250, 300, 500, 600, 1000, 5000, 10000, 20000, 37500, 75000};
        return t[c];
    endfunction
    // nominal 400 clocks at 25 sps; out-of-range trims fall back to the serial default
    function automatic int exp_trim(input logic [15:0] d);
        int s;
        s = int'($signed(d[7:0]));
        if (s > 50 || s < -50)
            s = 50 - SERIAL % 100;
        return 400 - 400 * s * 200 / 1000000;
    endfunction

    task automatic complete_run();
        if (n_fail == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up();
        n_fail++;
        complete_run();
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    // request held until ready is seen, so the accepting edge always has it
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(negedge sys_clk);
        cfg_wr = 1'b1;
        cfg_addr = a;
        cfg_data = d;
        while (cfg_ready !== 1'b1 && k < 50)
        begin
            @(negedge sys_clk);
            k++;
        end
        if (k >= 50)
            give_up();
        @(negedge sys_clk);
        cfg_wr = 1'b0;
        repeat (3) @(negedge sys_clk);
    endtask
    task automatic ticks(input int n);
        int k;
        k = 0;
        while (n > 0 && k < 100000)
        begin
            @(negedge sys_clk);
            k++;
            if (bus_tick === 1'b1)
                n--;
        end
        if (n > 0)
            give_up();
    endtask
    task automatic span(output int n);
        n = 0;
        do
        begin
            @(negedge sys_clk);
            n++;
        end
        while (conv_strobe !== 1'b1 && n < 50000);
        if (n >= 50000)
            give_up();
    endtask
    // first span only realigns, a setup change leaves a partial interval
    task automatic measure(input int exp);
        span(per);
        span(per);
        check("strobe_spacing", 32'(per), 32'(exp));
    endtask

    // main sequence
    initial
    begin
        sys_clk = 1'b0;
        rst = 1'b1;
        bus_cycle_us = 16'h000A;
        cfg_wr = 1'b0;
        cfg_addr = 2'h0;
        cfg_data = 16'h0000;
        n_fail = 0;
        checks_done = 0;
        lfsr_r = 32'h71341710;
        repeat (10) @(negedge sys_clk);
        rst = 1'b0;
        @(negedge sys_clk);
        check("range_reset", 32'(range_full_scale), 32'h10);
        check("state_reset", 32'(state_byte), 32'h0);
        for (int i = 0; i < 16; i++)
        begin
            wr(ADDR_SETUP, 16'(i * 17 & 8'h7F));
            check("rate_code", 32'(rate_code), 32'(i));
            check("range", 32'(range_full_scale), 32'(exp_range(3'(i))));
            check("range_ext", 32'(range_extended), 32'(i[2]));
            check("sync_mode", 32'(sync_mode), 32'(i == 14));
            check("valid", 32'(conv_valid), 32'(i < 14));
        end
        for (int i = 0; i < 14; i++)
        begin
            if (100000 % exp_dhz(i) == 0)
            begin
                wr(ADDR_SETUP, 16'(i));
                measure(100000 / exp_dhz(i));
            end
        end
        wr(ADDR_SETUP, 16'h000F);
        per = 0;
        repeat (5000)
        begin
            @(negedge sys_clk);
            if (conv_strobe === 1'b1)
                per++;
        end
        check("reserved_strobes", 32'(per), 32'h0);
        wr(ADDR_SETUP, 16'h0004);
        foreach (trims[i])
        begin
            wr(ADDR_TRIM, trims[i]);
            measure(exp_trim(trims[i]));
        end
        for (int i = 0; i < 24; i++)
        begin
            lfsr_r = lfsr(lfsr_r);
            wr(lfsr_r[1:0], lfsr_r[31:16]);
            if (lfsr_r[1:0] == ADDR_SETUP)
                check("rate_rand", 32'(rate_code), 32'(lfsr_r[19:16]));
        end
        wr(ADDR_SETUP, 16'h0000);
        wr(ADDR_TRIM, 16'h0032);
        wr(ADDR_PERIOD, 16'd200);
        wr(ADDR_SETUP, 16'h000E);
        ticks(3);
        check("settling_bit", 32'(state_byte[2]), 32'h1);
        ticks(137);
        check("settling_hold", 32'(state_byte[2]), 32'h1);
        ticks(12);
        check("locked_bit", 32'(state_byte[2]), 32'h0);
        check("locked_valid", 32'(conv_valid), 32'h1);
        measure(2000);
        wr(ADDR_PERIOD, 16'd205);
        ticks(3);
        check("resettle_bit", 32'(state_byte[2]), 32'h1);
        ticks(160);
        check("nolock_bit", 32'(state_byte[2]), 32'h1);
        wr(ADDR_PERIOD, 16'd100);
        ticks(2);
        complete_run();
    end
endmodule // bridge_adc_rate_sync_control_test
